//--- design/bfpi_pkg.sv
// Shared constants and types for the burst flash pin interface
package bfpi_pkg;
  localparam int ADDR_W     = 21;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int LAT_W      = 4;
  localparam int CTL_W      = 11;
  // Clock period and initial burst access times, in picoseconds
  localparam int SYS_CLK_PERIOD_PS = 10000;
  localparam int IACC_EVEN_PS      = 87500;
  localparam int IACC_ODD_PS       = 106000;
  // Longest times, so rounded down to whole cycles
  localparam int IACC_EVEN_CYC = IACC_EVEN_PS / SYS_CLK_PERIOD_PS;
  localparam int IACC_ODD_CYC  = IACC_ODD_PS / SYS_CLK_PERIOD_PS;
  localparam logic [LAT_W-1:0]  LAT_EVEN  = LAT_W'(IACC_EVEN_CYC);
  localparam logic [LAT_W-1:0]  LAT_ODD   = LAT_W'(IACC_ODD_CYC);
  localparam logic [LAT_W-1:0]  LAT_RST   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 21'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  // Pins reset to their idle levels so no false strobe edge follows reset;
  // the hardware reset bit stays active until the pin is really seen high
  localparam logic [CTL_W-1:0]  CTL_RST   = 11'h42e;
  // Bit positions inside the synchronised control vector
  localparam int CTL_FCLK  = 0;
  localparam int CTL_CE_N  = 1;
  localparam int CTL_OE_N  = 2;
  localparam int CTL_AVD_N = 3;
  localparam int CTL_RST_N = 4;
  localparam int CTL_WP_N  = 5;
  localparam int CTL_BOOST = 6;
  localparam int CTL_HV    = 7;
  localparam int CTL_BURST = 8;
  localparam int CTL_RWAIT = 9;
  localparam int CTL_WE_N  = 10;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ASYNC_FETCH,
    ST_BURST_WAIT,
    ST_BURST_RUN
  } bfpi_state_e;
endpackage

//--- design/bfpi_top.sv
// Burst flash pin interface: pin sampling, address latch, burst engine, word FIFO
// Notes on behaviour
// - Ready is low while the shown burst word is not valid, high when it is.
// - Asynchronous reads work with the flash clock standing still.
// - After the first burst word, each active clock edge with ready high advances the address by one.
// - In asynchronous mode a low address-valid strobe marks the address as valid.
// - In burst mode a low address-valid strobe latches a new burst start address.
// - With the address-valid strobe high, address inputs are ignored.
// - A low hardware reset resets the device back to reading array data.
// - Write-protect low refuses program and erase on the two outermost sectors.
// - Boost input at high voltage speeds programming and enables unlock bypass.
// - Boost input low treats every sector as locked; the code locks only while the high-voltage boost flag is also low.
// - Chip enable is taken without alignment to flash clock edges.
// - Output enable gates the data pins without alignment to flash clock edges.
// - Reduced-wait variant gives even start addresses a shorter first-word latency.
// - The rising flash clock edge is the active burst edge.
// - Asynchronous reads take the address at the strobe's rising edge.
`timescale 1ns/1ps
`default_nettype none

module bfpi_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 flush,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        count
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Honest full and empty straight from the occupancy
  assign in_ready  = (cnt_reg != (PW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign count     = cnt_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update; flush drops everything held
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) wr_next = (wr_reg == PW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_next = (rd_reg == PW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset, only written on a push
  always_ff @(posedge sys_clk) begin
    if (push && !flush) mem[wr_reg] <= in_data;
  end

  AST_FIFO_NO_OVERRUN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cnt_reg == (PW+1)'(D)) && !pop && !flush |=> cnt_reg == (PW+1)'(D))
    else $error("FIFO count changed while full without a pop");
endmodule

module bfpi_top
  import bfpi_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              flash_clk,
  input  wire logic              chip_en_n,
  input  wire logic              out_en_n,
  input  wire logic              write_en_n,
  input  wire logic              addr_valid_strobe_n,
  input  wire logic              hw_reset_n,
  input  wire logic              write_protect_n,
  input  wire logic              program_boost_input,
  input  wire logic              program_boost_hv,
  input  wire logic              burst_mode_sel,
  input  wire logic              reduced_wait_sel,
  input  wire logic [ADDR_W-1:0] word_address_bus,
  input  wire logic [DATA_W-1:0] data_bus_16_in,
  output logic [DATA_W-1:0]      data_bus_16_out,
  output logic                   data_bus_16_oe,
  output logic                   ready_out,
  output logic                   arr_rd_en,
  output logic [ADDR_W-1:0]      arr_rd_addr,
  input  wire logic [DATA_W-1:0] arr_rd_data,
  input  wire logic              pgm_req,
  input  wire logic              pgm_outer_sector,
  output logic                   pgm_grant,
  output logic                   pgm_refuse,
  output logic [DATA_W-1:0]      pgm_wdata,
  output logic                   accel_mode,
  output logic                   unlock_bypass,
  output logic                   all_locked,
  output logic                   read_array_mode
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // Two-flop synchronisers; the first stage feeds only the second
  logic [CTL_W-1:0]  ctl_s1_reg, ctl_s2_reg;
  logic [ADDR_W-1:0] adr_s1_reg, adr_s2_reg;
  logic [DATA_W-1:0] dat_s1_reg, dat_s2_reg;
  logic              fclk_d_reg, avd_d_reg;
  logic [CTL_W-1:0]  ctl_pins;
  assign ctl_pins = {write_en_n, reduced_wait_sel, burst_mode_sel, program_boost_hv,
                     program_boost_input, write_protect_n, hw_reset_n,
                     addr_valid_strobe_n, out_en_n, chip_en_n, flash_clk};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_s1_reg <= CTL_RST;
      ctl_s2_reg <= CTL_RST;
      adr_s1_reg <= ADDR_RST;
      adr_s2_reg <= ADDR_RST;
      dat_s1_reg <= DATA_RST;
      dat_s2_reg <= DATA_RST;
      fclk_d_reg <= 1'b0;
      avd_d_reg  <= 1'b1; // Strobe idles high
    end else begin
      ctl_s1_reg <= ctl_pins;
      ctl_s2_reg <= ctl_s1_reg;
      adr_s1_reg <= word_address_bus;
      adr_s2_reg <= adr_s1_reg;
      dat_s1_reg <= data_bus_16_in;
      dat_s2_reg <= dat_s1_reg;
      fclk_d_reg <= ctl_s2_reg[CTL_FCLK];
      avd_d_reg  <= ctl_s2_reg[CTL_AVD_N];
    end
  end

  logic s_ce_n, s_oe_n, s_avd_n, s_rst_n, s_wp_n, s_boost, s_hv, s_burst, s_rwait;
  logic clk_rise, avd_rise;
  assign s_ce_n   = ctl_s2_reg[CTL_CE_N];
  assign s_oe_n   = ctl_s2_reg[CTL_OE_N];
  assign s_avd_n  = ctl_s2_reg[CTL_AVD_N];
  assign s_rst_n  = ctl_s2_reg[CTL_RST_N];
  assign s_wp_n   = ctl_s2_reg[CTL_WP_N];
  assign s_boost  = ctl_s2_reg[CTL_BOOST];
  assign s_hv     = ctl_s2_reg[CTL_HV];
  assign s_burst  = ctl_s2_reg[CTL_BURST];
  assign s_rwait  = ctl_s2_reg[CTL_RWAIT];
  // Rising flash clock edge is the active burst edge
  assign clk_rise = ctl_s2_reg[CTL_FCLK] & ~fclk_d_reg;
  assign avd_rise = s_avd_n & ~avd_d_reg;

  // Word FIFO between array fetches and the data pins
  logic              f_flush, f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [DATA_W-1:0] f_out_data;
  logic [CW-1:0]     f_count;

  bfpi_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (arr_rd_data),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  bfpi_state_e       state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next, burst_addr_reg, burst_addr_next;
  logic [ADDR_W-1:0] fetch_addr_reg, fetch_addr_next;
  logic [ADDR_W-1:0] rdaddr_reg, rdaddr_next;
  logic [LAT_W-1:0]  lat_reg, lat_next;
  logic [DATA_W-1:0] dout_reg, dout_next, wdata_reg, wdata_next;
  logic              rdy_reg, rdy_next, oe_reg, oe_next, rd_reg, rd_next;
  logic              infl_reg, infl_next, fetch_reg, fetch_next;
  logic              grant_reg, grant_next, refuse_reg, refuse_next;
  logic              accel_reg, accel_next, locked_reg, locked_next, rdarr_reg;
  logic              burst_load, refused;
  logic [CW:0]       occ;

  // A stale in-flight word is dropped on flush; issue only with room left
  assign f_in_valid = infl_reg & ~f_flush;
  assign occ        = {1'b0, f_count} + (CW+1)'(rd_reg) + (CW+1)'(infl_reg);
  assign burst_load = s_burst & ~s_ce_n & ~s_avd_n & clk_rise;
  assign refused    = locked_reg | (~s_wp_n & pgm_outer_sector);

  // Next state of the read engine and the protection outputs
  always_comb begin
    state_next      = state_reg;
    addr_next       = addr_reg;
    burst_addr_next = burst_addr_reg;
    fetch_addr_next = fetch_addr_reg;
    rdaddr_next     = rdaddr_reg;
    lat_next        = (lat_reg != '0) ? lat_reg - 1'b1 : lat_reg;
    dout_next       = dout_reg;
    rdy_next        = rdy_reg;
    fetch_next      = fetch_reg;
    f_flush         = 1'b0;
    f_pop           = 1'b0;
    rd_next         = 1'b0;
    // Gating follows the synced enables, never the flash clock
    oe_next         = ~s_ce_n & ~s_oe_n & s_rst_n;
    accel_next      = s_hv;
    locked_next     = ~s_boost & ~s_hv;
    grant_next      = pgm_req & s_rst_n & ~refused;
    refuse_next     = pgm_req & refused;
    wdata_next      = (pgm_req & ~refused) ? dat_s2_reg : wdata_reg;
    if (!s_rst_n) begin
      // Hardware reset: drop the burst, back to array reads
      state_next = ST_IDLE;
      rdy_next   = 1'b0;
      fetch_next = 1'b0;
      f_flush    = 1'b1;
    end else if (burst_load) begin
      // New burst start; even start is faster on the reduced-wait variant
      addr_next       = adr_s2_reg;
      burst_addr_next = adr_s2_reg;
      fetch_addr_next = adr_s2_reg;
      lat_next        = (s_rwait && !adr_s2_reg[0]) ? LAT_EVEN : LAT_ODD;
      rdy_next        = 1'b0;
      fetch_next      = 1'b1;
      f_flush         = 1'b1;
      state_next      = ST_BURST_WAIT;
    end else if (s_ce_n && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
      rdy_next   = 1'b0;
      fetch_next = 1'b0;
      f_flush    = 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // Address tracked only while the strobe is low, taken at its rise
          if (!s_avd_n) addr_next = adr_s2_reg;
          if (avd_rise && !s_burst && !s_ce_n) begin
            fetch_addr_next = addr_reg;
            fetch_next      = 1'b1;
            f_flush         = 1'b1;
            state_next      = ST_ASYNC_FETCH;
          end
        end
        ST_ASYNC_FETCH: begin
          fetch_next = 1'b0;
          if (f_out_valid) begin
            f_pop      = 1'b1;
            dout_next  = f_out_data;
            rdy_next   = 1'b1;
            state_next = ST_IDLE;
          end
        end
        ST_BURST_WAIT: begin
          if (lat_reg == '0 && f_out_valid) begin
            f_pop      = 1'b1;
            dout_next  = f_out_data;
            rdy_next   = 1'b1;
            state_next = ST_BURST_RUN;
          end
        end
        ST_BURST_RUN: begin
          // Host takes a word on each edge with ready high
          if (clk_rise && rdy_reg) begin
            burst_addr_next = burst_addr_reg + 1'b1;
            f_pop           = f_out_valid;
            dout_next       = f_out_valid ? f_out_data : dout_reg;
            rdy_next        = f_out_valid;
          end else if (!rdy_reg && f_out_valid) begin
            f_pop     = 1'b1;
            dout_next = f_out_data;
            rdy_next  = 1'b1;
          end
        end
      endcase
    end
    // Array fetch: async reads stop after one word
    if (fetch_reg && f_in_ready && !f_flush && occ < (CW+1)'(FIFO_DEPTH)) begin
      rd_next         = 1'b1;
      rdaddr_next     = fetch_addr_reg; // Issued address stands with the strobe
      fetch_addr_next = fetch_addr_reg + 1'b1;
      if (state_reg == ST_IDLE) fetch_next = 1'b0;
    end
    infl_next = rd_reg & ~f_flush;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_IDLE;
      addr_reg       <= ADDR_RST;
      burst_addr_reg <= ADDR_RST;
      fetch_addr_reg <= ADDR_RST;
      rdaddr_reg     <= ADDR_RST;
      lat_reg        <= LAT_RST;
      dout_reg       <= DATA_RST;
      wdata_reg      <= DATA_RST;
      rdy_reg        <= 1'b0;
      oe_reg         <= 1'b0;
      rd_reg         <= 1'b0;
      infl_reg       <= 1'b0;
      fetch_reg      <= 1'b0;
      grant_reg      <= 1'b0;
      refuse_reg     <= 1'b0;
      accel_reg      <= 1'b0;
      locked_reg     <= 1'b1;
      rdarr_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      addr_reg       <= addr_next;
      burst_addr_reg <= burst_addr_next;
      fetch_addr_reg <= fetch_addr_next;
      rdaddr_reg     <= rdaddr_next;
      lat_reg        <= lat_next;
      dout_reg       <= dout_next;
      wdata_reg      <= wdata_next;
      rdy_reg        <= rdy_next;
      oe_reg         <= oe_next;
      rd_reg         <= rd_next;
      infl_reg       <= infl_next;
      fetch_reg      <= fetch_next;
      grant_reg      <= grant_next;
      refuse_reg     <= refuse_next;
      accel_reg      <= accel_next;
      locked_reg     <= locked_next;
      rdarr_reg      <= s_rst_n;
    end
  end

  // Every output is a flip-flop
  assign data_bus_16_out = dout_reg;
  assign data_bus_16_oe  = oe_reg;
  assign ready_out       = rdy_reg;
  assign arr_rd_en       = rd_reg;
  assign arr_rd_addr     = rdaddr_reg;
  assign pgm_grant       = grant_reg;
  assign pgm_refuse      = refuse_reg;
  assign pgm_wdata       = wdata_reg;
  assign accel_mode      = accel_reg;
  assign unlock_bypass   = accel_reg;
  assign all_locked      = locked_reg;
  assign read_array_mode = rdarr_reg;

  AST_RESET_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !s_rst_n |=> state_reg == ST_IDLE && !rdy_reg && !oe_reg)
    else $error("Hardware reset did not return to idle");
  AST_CE_GATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_ce_n |=> !oe_reg)
    else $error("Data driven with chip disabled");
  AST_OE_GATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !s_ce_n && !s_oe_n && s_rst_n |=> oe_reg)
    else $error("Data not driven with outputs enabled");
  AST_ADDR_ADVANCE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_reg == ST_BURST_RUN && clk_rise && rdy_reg && s_rst_n && !s_ce_n && !burst_load
    |=> burst_addr_reg == $past(burst_addr_reg) + 1'b1)
    else $error("Burst address did not advance on active edge");
  AST_AVD_IGNORE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_avd_n && s_rst_n |=> addr_reg == $past(addr_reg))
    else $error("Address changed while strobe high");
  AST_WP_REFUSE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pgm_req && !s_wp_n && pgm_outer_sector |=> pgm_refuse && !pgm_grant)
    else $error("Protected outer sector was not refused");
  AST_LOCK_ALL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !s_boost && !s_hv ##1 (!s_boost && !s_hv && pgm_req) |=> pgm_refuse)
    else $error("Program accepted with boost input low");
  AST_ACCEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(s_hv) |=> accel_mode && unlock_bypass && !all_locked)
    else $error("High voltage boost did not enter fast mode");
  AST_LAT_EVEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    burst_load && s_rst_n && s_rwait && !adr_s2_reg[0] |=> lat_reg == LAT_EVEN)
    else $error("Even start did not get the short latency");
  AST_RDY_LOW_WAIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    burst_load && s_rst_n |=> !rdy_reg ##1 !rdy_reg)
    else $error("Ready high before initial latency elapsed");
endmodule

`default_nettype wire

//--- test/bfpi_host_model.sv
// Host memory controller model driving the flash bus strobes
`timescale 1ns/1ps
`default_nettype none

module bfpi_host_model
  import bfpi_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              ready_out,
  input  wire logic [DATA_W-1:0] data_bus_16_out,
  output logic                   flash_clk,
  output logic                   chip_en_n,
  output logic                   out_en_n,
  output logic                   addr_valid_strobe_n,
  output logic [ADDR_W-1:0]      word_address_bus
);
  // Phase length in system cycles; raised for a slow host
  int hold_cyc = 3;

  // Idle bus: deselected, clock standing still
  initial begin
    flash_clk = 1'b0;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    addr_valid_strobe_n = 1'b1;
    word_address_bus = '0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Load a start address; only a burst toggles the clock
  task automatic start(input logic [ADDR_W-1:0] a, input logic burst);
    chip_en_n = 1'b0;
    out_en_n = 1'b0;
    word_address_bus = a;
    addr_valid_strobe_n = 1'b0;
    wait_n(hold_cyc);
    if (burst) flash_clk = 1'b1;
    wait_n(hold_cyc);
    addr_valid_strobe_n = 1'b1;
    flash_clk = 1'b0;
    wait_n(1);
    // Released address is garbage, so a leaky latch shows up
    word_address_bus = ~a;
    wait_n(hold_cyc);
  endtask

  // Wait for ready, bounded at 300 cycles; data taken once ready is high or the bound runs out
  task automatic read_word(output logic [DATA_W-1:0] d, output int n, output bit ok);
    n = 0;
    while (ready_out !== 1'b1 && n < 300) begin
      wait_n(1);
      n++;
    end
    ok = (n < 300);
    d = data_bus_16_out;
  endtask

  // One active edge asks for the next word
  task automatic advance();
    flash_clk = 1'b1;
    wait_n(hold_cyc);
    flash_clk = 1'b0;
    wait_n(hold_cyc);
  endtask

  task automatic stop();
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    wait_n(6);
  endtask
endmodule

`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the burst flash pin interface
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import bfpi_pkg::*;
  logic sys_clk = 1'b0, arst_n, hw_reset_n, write_protect_n, program_boost_input;
  logic program_boost_hv, burst_mode_sel, reduced_wait_sel, pgm_req, pgm_outer_sector;
  logic flash_clk, chip_en_n, out_en_n, addr_valid_strobe_n, data_bus_16_oe, ready_out;
  logic arr_rd_en, pgm_grant, pgm_refuse, accel_mode, unlock_bypass, all_locked;
  logic read_array_mode;
  logic [ADDR_W-1:0] word_address_bus, arr_rd_addr, ra;
  logic [DATA_W-1:0] data_bus_16_in, data_bus_16_out, pgm_wdata;
  logic [DATA_W-1:0] arr_rd_data = '0;
  int failures = 0, checks_done = 0, le, lo, se, so;
  logic [DATA_W-1:0] exp_q[$];

  always #5 sys_clk = ~sys_clk;

  bfpi_top u_bfpi_top (.sys_clk(sys_clk), .arst_n(arst_n), .flash_clk(flash_clk),
    .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(1'b1),
    .addr_valid_strobe_n(addr_valid_strobe_n), .hw_reset_n(hw_reset_n),
    .write_protect_n(write_protect_n), .program_boost_input(program_boost_input),
    .program_boost_hv(program_boost_hv), .burst_mode_sel(burst_mode_sel),
    .reduced_wait_sel(reduced_wait_sel), .word_address_bus(word_address_bus),
    .data_bus_16_in(data_bus_16_in), .data_bus_16_out(data_bus_16_out),
    .data_bus_16_oe(data_bus_16_oe), .ready_out(ready_out), .arr_rd_en(arr_rd_en),
    .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data), .pgm_req(pgm_req),
    .pgm_outer_sector(pgm_outer_sector), .pgm_grant(pgm_grant), .pgm_refuse(pgm_refuse),
    .pgm_wdata(pgm_wdata), .accel_mode(accel_mode), .unlock_bypass(unlock_bypass),
    .all_locked(all_locked), .read_array_mode(read_array_mode));

  bfpi_host_model u_host (.sys_clk(sys_clk), .ready_out(ready_out),
    .data_bus_16_out(data_bus_16_out), .flash_clk(flash_clk), .chip_en_n(chip_en_n),
    .out_en_n(out_en_n), .addr_valid_strobe_n(addr_valid_strobe_n),
    .word_address_bus(word_address_bus));

  // Array contents are a scramble of the address, one cycle behind the strobe
  function automatic logic [DATA_W-1:0] arr_fn(input logic [ADDR_W-1:0] a);
    return 16'(a) ^ 16'(a >> 5) ^ 16'h5a3c;
  endfunction

  always @(posedge sys_clk) if (arr_rd_en === 1'b1) arr_rd_data <= arr_fn(arr_rd_addr);

  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A hung handshake ends the run as a failure
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  task automatic prog(input logic boost, input logic wp, input logic outer, input logic hv);
    logic [DATA_W-1:0] d;
    logic r;
    d = 16'($urandom);
    r = (!boost && !hv) || (!wp && outer);
    program_boost_input = boost;
    write_protect_n = wp;
    program_boost_hv = hv;
    pgm_outer_sector = outer;
    data_bus_16_in = d;
    repeat (5) @(negedge sys_clk);
    pgm_req = 1'b1;
    @(negedge sys_clk);
    pgm_req = 1'b0;
    // Grant or refusal stands only in the cycle after the request edge
    check("pgm_refuse", pgm_refuse, r);
    check("pgm_grant", pgm_grant, !r);
    if (!r) check("pgm_wdata", pgm_wdata, d);
    @(negedge sys_clk);
    check("all_locked", all_locked, !boost && !hv);
    check("accel_mode", accel_mode, hv);
    check("unlock_bypass", unlock_bypass, hv);
  endtask

  // Burst of len words; expected words queued from the address counter model
  task automatic burst(input logic [ADDR_W-1:0] a, input logic rw, input int len,
                       output int lat);
    logic [DATA_W-1:0] d;
    int n;
    bit ok;
    reduced_wait_sel = rw;
    burst_mode_sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < len; i++) exp_q.push_back(arr_fn(a + 21'(i)));
    u_host.start(a, 1'b1);
    for (int i = 0; i < len; i++) begin
      if (i > 0) u_host.advance();
      u_host.read_word(d, n, ok);
      if (!ok) begin
        failures++;
        close_out();
      end
      // Latency counted from the clock rise the host gave inside start
      if (i == 0) lat = n + 2 * u_host.hold_cyc + 1;
      if (i > 0) check("burst_no_wait", n, 0);
      check("burst_word", d, exp_q.pop_front());
      check("data_oe", data_bus_16_oe, 1'b1);
      if (i == 0) begin
        // Prefetch halts once the FIFO is full behind the shown word
        repeat (FIFO_DEPTH + 8) @(negedge sys_clk);
        check("fifo_full_stop", arr_rd_en, 1'b0);
        check("fifo_last_addr", arr_rd_addr, 21'(a + 21'(FIFO_DEPTH)));
      end
    end
    repeat (8) @(negedge sys_clk);
    check("fifo_refill_stop", arr_rd_en, 1'b0);
    check("fifo_refill_addr", arr_rd_addr, 21'(a + 21'(len - 1 + FIFO_DEPTH)));
    check("lat_min", lat >= 3 + int'((rw && !a[0]) ? LAT_EVEN : LAT_ODD), 1'b1);
    u_host.stop();
    check("ready_after_ce", ready_out, 1'b0);
    check("oe_after_ce", data_bus_16_oe, 1'b0);
    check("fifo_flush_rd", arr_rd_en, 1'b0);
  endtask

  initial begin
    logic [DATA_W-1:0] d;
    int n;
    bit ok;
    void'($urandom(32'hdef3_93bc));
    {arst_n, burst_mode_sel, reduced_wait_sel, pgm_req, pgm_outer_sector} = '0;
    {hw_reset_n, write_protect_n, program_boost_input, program_boost_hv} = 4'b1110;
    data_bus_16_in = '0;
    repeat (10) @(negedge sys_clk);
    check("all_locked_rst", all_locked, 1'b1);
    check("ready_rst", ready_out, 1'b0);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("read_array_mode", read_array_mode, 1'b1);
    for (int k = 0; k < 8; k++) prog(k[0], k[1], k[2], 1'b0);
    prog(1'b0, 1'b1, 1'b0, 1'b1);
    prog(1'b1, 1'b1, 1'b1, 1'b0);
    // Asynchronous read with the flash clock held low
    ra = 21'($urandom);
    u_host.start(ra, 1'b0);
    u_host.read_word(d, n, ok);
    check("async_ok", ok, 1'b1);
    check("async_word", d, arr_fn(ra));
    u_host.stop();
    ra = 21'($urandom) & 21'h1f_fffe;
    burst(ra, 1'b1, 4, le);
    burst(ra | 21'h00_0001, 1'b1, 4, lo);
    check("odd_slower", lo > le, 1'b1);
    burst(ra, 1'b0, 4, se);
    burst(ra | 21'h00_0001, 1'b0, 4, so);
    check("std_same_lat", se, so);
    // Long slow burst wraps both FIFO pointers and the 21-bit address
    u_host.hold_cyc = 6;
    burst(21'h1f_fffe, 1'b1, 20, le);
    u_host.hold_cyc = 3;
    // Pin reset in mid-burst drops the burst and leaves array read mode
    u_host.start(ra, 1'b1);
    u_host.read_word(d, n, ok);
    hw_reset_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check("pin_rst_ready", ready_out, 1'b0);
    check("pin_rst_mode", read_array_mode, 1'b0);
    hw_reset_n = 1'b1;
    u_host.stop();
    check("pin_rst_back", read_array_mode, 1'b1);
    close_out();
  end
endmodule

`default_nettype wire
